// [hdl/fvc_dev.sv]
// Purpose: flash side volatile read config register and read sequencing
// Assumes: link clock and select sampled by core clock, mode 0 link
// Notes:   internal config follows the volatile register at frame end
//
// Contract
// - config only through dedicated read/write commands
// - completed access copies register into internal config
// - bits 7:4 dummy count, zero means fifteen
// - bit 3 low enables execute in place
// - wrap codes select 16, 32, 64 byte blocks
// - wrapped read starts at address, returns to base
// - wrap code 11 reads on continuously
// - host programs enough dummy cycles
// - host keeps single rate clock within limits
// - host keeps double rate clock within limits
// - device offers a sampling tune pattern
// - double rate samples data on both edges
`timescale 1ns/1ns
module fvc_dev
  import fvc_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  fvc_link_if.dev          link,
  input  wire logic        double_rate_i,
  input  wire logic [7:0]  mem_data_i,
  output logic      [23:0] mem_addr_o,
  output logic      [7:0]  internal_cfg_o,
  output logic             execute_in_place_o
);
  typedef enum logic [6:0] {
    D_IDLE  = 7'h01,
    D_CMD   = 7'h02,
    D_ADDR  = 7'h04,
    D_WDATA = 7'h08,
    D_DUMMY = 7'h10,
    D_OUT   = 7'h20,
    D_SKIP  = 7'h40
  } fvc_dev_state_t;

  typedef struct packed {
    fvc_dev_state_t state;
    logic           sclk_prev;
    logic           cs_prev;
    logic           ddr;
    logic [4:0]     cnt;
    logic [23:0]    sh;
    logic [7:0]     cmd;
    logic [3:0]     dcnt;
    logic [7:0]     out_sh;
    logic [2:0]     obit;
    logic [23:0]    addr;
    logic           miso;
    logic           done;
    logic [7:0]     vcr;
    logic [7:0]     cfg;
    logic           xip_en;
  } fvc_dev_regs_t;

  localparam fvc_dev_regs_t DEV_RESET = '{
    state:     D_IDLE,
    sclk_prev: 1'b0,
    cs_prev:   1'b1,
    ddr:       1'b0,
    cnt:       5'h00,
    sh:        24'h000000,
    cmd:       8'h00,
    dcnt:      4'h0,
    out_sh:    8'h00,
    obit:      3'h0,
    addr:      24'h000000,
    miso:      1'b0,
    done:      1'b0,
    vcr:       CFG_RESET,
    cfg:       CFG_RESET,
    xip_en:    1'b0
  };

  fvc_dev_regs_t r_reg;
  fvc_dev_regs_t r_next;
  logic [2:0]    sync_in;
  logic [2:0]    sync_q;
  logic          sclk_s;
  logic          cs_n_s;
  logic          mosi_s;
  logic          rise;
  logic          fall;
  logic          cap;
  logic          drv;
  logic [7:0]    cmd_now;
  logic [7:0]    wval;
  logic [7:0]    fresh;
  logic [7:0]    cur_byte;

  // pins come from another clock, select idles high
  assign sync_in = {link.sclk, link.cs_n, link.mosi};

  fvc_sync #(
    .W   (3),
    .RST (3'b010)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .d_i        (sync_in),
    .q_o        (sync_q)
  );

  assign sclk_s = sync_q[2];
  assign cs_n_s = sync_q[1];
  assign mosi_s = sync_q[0];

  // link edges; data and clock share sync delay so capture lines up
  assign rise = sclk_s & ~r_reg.sclk_prev;
  assign fall = ~sclk_s & r_reg.sclk_prev;
  assign cap  = rise | (r_reg.ddr & fall);
  assign drv  = fall | (r_reg.ddr & rise);

  // command byte as it completes, then the held one
  assign cmd_now = (r_reg.state == D_CMD) ? {r_reg.sh[6:0], mosi_s} : r_reg.cmd;
  assign wval    = r_reg.sh[7:0] & ~CFG_RSVD_MASK;

  // byte source per read command
  always_comb begin
    if (cmd_now == CMD_RD_CFG) begin
      fresh = r_reg.vcr;
    end else if (cmd_now == CMD_FAST_RD) begin
      fresh = mem_data_i;
    end else begin
      fresh = TUNE_PATTERN;
    end
  end

  // a new byte is fetched at its first drive event only
  assign cur_byte = (r_reg.obit == 3'h0) ? fresh : r_reg.out_sh;

  // frame sequencing, register update and output shifting
  always_comb begin
    r_next           = r_reg;
    r_next.sclk_prev = sclk_s;
    r_next.cs_prev   = cs_n_s;
    if (cs_n_s) begin
      r_next.state = D_IDLE;
      r_next.done  = 1'b0;
      if (!r_reg.cs_prev && r_reg.done) begin
        // copy only when the access really finished
        if (r_reg.cmd == CMD_WR_CFG) begin
          r_next.vcr    = wval;
          r_next.cfg    = wval;
          r_next.xip_en = ~wval[CFG_XIP_BIT];
        end else begin
          r_next.cfg    = r_reg.vcr;
          r_next.xip_en = ~r_reg.vcr[CFG_XIP_BIT];
        end
      end
    end else if (r_reg.cs_prev) begin
      // frame start; rate is frozen for the whole frame
      r_next.state = D_CMD;
      r_next.cnt   = 5'h00;
      r_next.obit  = 3'h0;
      r_next.ddr   = double_rate_i;
    end else begin
      if (cap) begin
        r_next.sh  = {r_reg.sh[22:0], mosi_s};
        r_next.cnt = r_reg.cnt + 5'h01;
      end
      unique case (r_reg.state)
        D_CMD: begin
          if (cap && r_reg.cnt == 5'h07) begin
            r_next.cnt  = 5'h00;
            r_next.dcnt = 4'h0;
            r_next.cmd  = cmd_now;
            if (cmd_now == CMD_RD_CFG) begin
              r_next.state = D_OUT;
              r_next.done  = 1'b1;
            end else if (cmd_now == CMD_WR_CFG) begin
              r_next.state = D_WDATA;
            end else if (cmd_now == CMD_FAST_RD) begin
              r_next.state = D_ADDR;
            end else if (cmd_now == CMD_TUNE_RD) begin
              r_next.state = D_DUMMY;
            end else begin
              r_next.state = D_SKIP;
            end
          end
        end
        D_ADDR: begin
          if (cap && r_reg.cnt == 5'h17) begin
            r_next.addr  = {r_reg.sh[22:0], mosi_s};
            r_next.state = D_DUMMY;
          end
        end
        D_WDATA: begin
          // extra bits after the data byte still shift in; the last 8 captured are written
          if (cap && r_reg.cnt == 5'h07) begin
            r_next.done  = 1'b1;
            r_next.state = D_SKIP;
          end
        end
        D_DUMMY: begin
          // dummy cycles are whole clocks in either rate
          if (rise) begin
            r_next.dcnt = r_reg.dcnt + 4'h1;
            if (r_reg.dcnt + 4'h1 == fvc_dummy_count(r_reg.cfg)) begin
              r_next.state = D_OUT;
            end
          end
        end
        D_OUT, D_SKIP, D_IDLE: begin
          r_next.cnt = r_reg.cnt;
        end
        default: begin
          r_next.state = D_SKIP;
        end
      endcase
      // drive after capture so a double rate entry drives at once
      if (r_next.state == D_OUT && drv) begin
        r_next.miso   = cur_byte[7];
        r_next.out_sh = {cur_byte[6:0], 1'b0};
        r_next.obit   = r_reg.obit + 3'h1;
        if (r_reg.obit == 3'h0 && cmd_now == CMD_FAST_RD) begin
          r_next.addr = fvc_wrap_next(r_reg.addr, r_reg.cfg[CFG_WRAP_LSB +: 2]);
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= DEV_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from state
  assign link.miso          = r_reg.miso;
  assign mem_addr_o         = r_reg.addr;
  assign internal_cfg_o     = r_reg.cfg;
  assign execute_in_place_o = r_reg.xip_en;
endmodule

// [hdl/fvc_host.sv]
// Purpose: controller end issuing config and read commands on the link
// Assumes: software drives the plain register port on core clock
// Notes:   link stalls between read bytes until software takes the data
`timescale 1ns/1ns
module fvc_host
  import fvc_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  fvc_link_if.host         link,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o
);
  typedef enum logic [4:0] {
    H_IDLE  = 5'h01,
    H_TX    = 5'h02,
    H_DUMMY = 5'h04,
    H_RX    = 5'h08,
    H_END   = 5'h10
  } fvc_host_state_t;

  typedef struct packed {
    fvc_host_state_t state;
    logic [1:0]      q;
    logic            mid;
    logic            sclk;
    logic            cs_n;
    logic            mosi;
    logic [31:0]     tx_sh;
    logic [5:0]      txn;
    logic [3:0]      dcnt;
    logic [7:0]      rx_sh;
    logic [2:0]      rbit;
    logic [8:0]      nbytes;
    logic [7:0]      rdata;
    logic            rxv;
    logic            ddr;
    fvc_op_t         op;
    logic [7:0]      cfg;
    logic [23:0]     addr;
    logic [7:0]      wbyte;
    logic [7:0]      len;
    logic [31:0]     bus_rdata;
  } fvc_host_regs_t;

  fvc_host_regs_t r_reg;
  fvc_host_regs_t r_next;
  logic           miso_s;
  logic           busy;
  logic           tick;
  logic           stall;
  logic           cap_e;
  fvc_op_t        op_w;
  logic [7:0]     byte_in;

  fvc_sync #(
    .W   (1),
    .RST (1'b0)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .d_i        (link.miso),
    .q_o        (miso_s)
  );

  assign busy    = (r_reg.state != H_IDLE);
  assign tick    = (r_reg.q == Q_LAST);
  // back-pressure: hold the link clock until the last byte is read
  assign stall   = (r_reg.state == H_RX) && r_reg.rxv && (r_reg.rbit == 3'h0);
  assign cap_e   = ~r_reg.sclk | r_reg.ddr;
  assign op_w    = fvc_op_t'(reg_wdata_i[CTRL_OP_LSB +: 2]);
  assign byte_in = {r_reg.rx_sh[6:0], miso_s};

  always_comb begin
    r_next           = r_reg;
    r_next.bus_rdata = 32'h0000_0000;
    // register reads; unmapped offsets read zero
    if (reg_rd_i) begin
      case (reg_addr_i)
        REG_CTRL: r_next.bus_rdata = {29'h0, r_reg.ddr, r_reg.op};
        REG_ADDR: r_next.bus_rdata = {8'h00, r_reg.addr};
        REG_DATA: r_next.bus_rdata = {16'h0000, r_reg.len, r_reg.wbyte};
        REG_STATUS: begin
          r_next.bus_rdata[STAT_BUSY_BIT]       = busy;
          r_next.bus_rdata[STAT_RXV_BIT]        = r_reg.rxv;
          r_next.bus_rdata[STAT_CFG_LSB +: 8]   = r_reg.cfg;
        end
        REG_RDATA: begin
          r_next.bus_rdata = {24'h000000, r_reg.rdata};
          r_next.rxv       = 1'b0;
        end
        default: r_next.bus_rdata = 32'h0000_0000;
      endcase
    end
    // register writes; start ignored while busy
    if (reg_wr_i) begin
      if (reg_addr_i == REG_ADDR) begin
        r_next.addr = reg_wdata_i[23:0];
      end
      if (reg_addr_i == REG_DATA) begin
        r_next.wbyte = reg_wdata_i[DATA_WBYTE_LSB +: 8];
        r_next.len   = reg_wdata_i[DATA_LEN_LSB +: 8];
      end
      if (reg_addr_i == REG_CTRL && !busy && reg_wdata_i[CTRL_START_BIT]) begin
        r_next.op     = op_w;
        r_next.ddr    = reg_wdata_i[CTRL_DDR_BIT];
        r_next.state  = H_TX;
        r_next.cs_n   = 1'b0;
        r_next.q      = 2'h0;
        r_next.mid    = 1'b1;
        r_next.rbit   = 3'h0;
        r_next.dcnt   = 4'h0;
        r_next.nbytes = {1'b0, r_reg.len} + 9'h001;
        unique case (op_w)
          OP_RD_CFG: begin
            r_next.tx_sh = {CMD_RD_CFG, 24'h000000};
            r_next.txn   = 6'h08;
          end
          OP_WR_CFG: begin
            r_next.tx_sh  = {CMD_WR_CFG, r_reg.wbyte, 16'h0000};
            r_next.txn    = 6'h10;
            r_next.nbytes = 9'h000;
            r_next.cfg    = r_reg.wbyte & ~CFG_RSVD_MASK;
          end
          OP_FAST_RD: begin
            r_next.tx_sh = {CMD_FAST_RD, r_reg.addr};
            r_next.txn   = 6'h20;
            r_next.dcnt  = fvc_dummy_count(r_reg.cfg);
          end
          OP_TUNE_RD: begin
            r_next.tx_sh = {CMD_TUNE_RD, 24'h000000};
            r_next.txn   = 6'h08;
            r_next.dcnt  = fvc_dummy_count(r_reg.cfg);
          end
        endcase
      end
    end
    // link sequencer: quarters alternate data change and clock edge
    if (busy && !stall) begin
      r_next.q = tick ? 2'h0 : r_reg.q + 2'h1;
      if (tick) begin
        r_next.mid = ~r_reg.mid;
        if (r_reg.mid) begin
          if (r_reg.state == H_TX && (r_reg.ddr || !r_reg.sclk)) begin
            r_next.mosi  = r_reg.tx_sh[31];
            r_next.tx_sh = {r_reg.tx_sh[30:0], 1'b0};
          end
        end else if (r_reg.state == H_END) begin
          // park the clock low, then release select
          if (r_reg.sclk) begin
            r_next.sclk = 1'b0;
          end else begin
            r_next.cs_n  = 1'b1;
            r_next.state = H_IDLE;
          end
        end else begin
          r_next.sclk = ~r_reg.sclk;
          if (r_reg.state == H_TX && cap_e) begin
            r_next.txn = r_reg.txn - 6'h01;
            if (r_reg.txn == 6'h01) begin
              r_next.state = (r_reg.dcnt != 4'h0) ? H_DUMMY :
                             (r_reg.nbytes != 9'h000) ? H_RX : H_END;
            end
          end
          if (r_reg.state == H_DUMMY && !r_reg.sclk) begin
            r_next.dcnt = r_reg.dcnt - 4'h1;
            if (r_reg.dcnt == 4'h1) begin
              r_next.state = H_RX;
            end
          end
          if (r_reg.state == H_RX && cap_e) begin
            r_next.rx_sh = byte_in;
            r_next.rbit  = r_reg.rbit + 3'h1;
            if (r_reg.rbit == 3'h7) begin
              r_next.rdata  = byte_in;
              r_next.rxv    = 1'b1; // set wins over the read clear
              r_next.nbytes = r_reg.nbytes - 9'h001;
              if (r_reg.op == OP_RD_CFG) begin
                r_next.cfg = byte_in;
              end
              if (r_reg.nbytes == 9'h001) begin
                r_next.state = H_END;
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= '{state: H_IDLE, q: 2'h0, mid: 1'b0, sclk: 1'b0, cs_n: 1'b1,
                 mosi: 1'b0, tx_sh: 32'h0, txn: 6'h0, dcnt: 4'h0, rx_sh: 8'h00,
                 rbit: 3'h0, nbytes: 9'h000, rdata: 8'h00, rxv: 1'b0, ddr: 1'b0,
                 op: OP_RD_CFG, cfg: CFG_RESET, addr: 24'h0, wbyte: 8'h00,
                 len: 8'h00, bus_rdata: 32'h0};
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from state
  assign link.sclk   = r_reg.sclk;
  assign link.cs_n   = r_reg.cs_n;
  assign link.mosi   = r_reg.mosi;
  assign reg_rdata_o = r_reg.bus_rdata;
endmodule

// [hdl/fvc_link_if.sv]
// Purpose: serial link between controller and flash config logic
// Assumes: controller makes the link clock and select
// Notes:   single data line each way, no tristate needed
`timescale 1ns/1ns
interface fvc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport host (output sclk, output cs_n, output mosi, input miso);
  modport dev  (input sclk, input cs_n, input mosi, output miso);
endinterface

// [hdl/fvc_pkg.sv]
// Purpose: shared constants and helpers of the volatile read config link
// Assumes: core clock 100 MHz, serial link mode 0 (clock idles low)
// Notes:   command codes and pattern byte are fixed by this team
package fvc_pkg;
  // serial commands
  localparam logic [7:0] CMD_RD_CFG   = 8'h85;
  localparam logic [7:0] CMD_WR_CFG   = 8'h81;
  localparam logic [7:0] CMD_FAST_RD  = 8'h0B;
  localparam logic [7:0] CMD_TUNE_RD  = 8'h5A;
  // config byte layout and reset value
  localparam logic [7:0] CFG_RESET     = 8'hFB;
  localparam int         CFG_DUMMY_LSB = 4;
  localparam int         CFG_XIP_BIT   = 3;
  localparam logic [7:0] CFG_RSVD_MASK = 8'h04;
  localparam int         CFG_WRAP_LSB  = 0;
  localparam logic [3:0] DUMMY_ALIAS   = 4'h0;
  localparam logic [3:0] DUMMY_DEFAULT = 4'hF;
  localparam logic [1:0] WRAP_16       = 2'h0;
  localparam logic [1:0] WRAP_32       = 2'h1;
  localparam logic [1:0] WRAP_64       = 2'h2;
  localparam logic [7:0] TUNE_PATTERN  = 8'hC3;
  // link timing: 160 ns clock keeps every read type far below its limit
  localparam int         CLK_PERIOD_NS   = 10;
  localparam int         SCK_PERIOD_NS   = 160;
  localparam int         SCK_QUARTER_CYC = SCK_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [1:0] Q_LAST          = 2'(SCK_QUARTER_CYC - 1);
  // controller register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_DDR_BIT   = 2;
  localparam int CTRL_START_BIT = 3;
  localparam int DATA_WBYTE_LSB = 0;
  localparam int DATA_LEN_LSB   = 8;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_RXV_BIT   = 1;
  localparam int STAT_CFG_LSB   = 8;

  typedef enum logic [1:0] {
    OP_RD_CFG  = 2'h0,
    OP_WR_CFG  = 2'h1,
    OP_FAST_RD = 2'h2,
    OP_TUNE_RD = 2'h3
  } fvc_op_t;

  // effective dummy count, code zero aliases the default
  function automatic logic [3:0] fvc_dummy_count(input logic [7:0] cfg);
    logic [3:0] code;
    code = cfg[CFG_DUMMY_LSB +: 4];
    return (code == DUMMY_ALIAS) ? DUMMY_DEFAULT : code;
  endfunction

  // next read address, wrapping inside the aligned block
  function automatic logic [23:0] fvc_wrap_next(input logic [23:0] a,
                                                input logic [1:0]  wrap);
    logic [23:0] inc;
    logic [23:0] m;
    inc = a + 24'h000001;
    case (wrap)
      WRAP_16: m = 24'h00000F;
      WRAP_32: m = 24'h00001F;
      WRAP_64: m = 24'h00003F;
      default: m = 24'hFFFFFF;
    endcase
    return (a & ~m) | (inc & m);
  endfunction
endpackage

// [hdl/fvc_sync.sv]
// Purpose: two flip-flop synchroniser for link pins
// Assumes: inputs are asynchronous levels
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
module fvc_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fvc_sync_state_t;

  fvc_sync_state_t r_reg;
  fvc_sync_state_t r_next;

  // two stages, reset to the idle pin level
  always_comb begin
    r_next.s1 = d_i;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= '{s1: RST, s2: RST};
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_o = r_reg.s2;
endmodule

// [verif/fvc_link_chk.sv]
// Purpose: link timing and config checks
// Assumes: link quarter of 4 core cycles
// Notes:   half periods are floors; a read stall may stretch either half
`timescale 1ns/1ns
module fvc_link_chk (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic       sclk_i,
  input wire logic       cs_n_i,
  input wire logic       mosi_i,
  input wire logic       miso_i,
  input wire logic [7:0] internal_cfg_i,
  input wire logic       execute_in_place_i
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // minimum half periods; back-pressure holds the clock at a byte end
  sequence high_half;
    sclk_i [*8];
  endsequence
  sequence low_half;
    !sclk_i [*8];
  endsequence
  // clock parked low outside frames
  idle_clock_a: assert property (cs_n_i |-> !sclk_i)
    else $error("link clock moves while deselected");
  frame_lead_a: assert property ($fell(cs_n_i) |-> !sclk_i [*4])
    else $error("first clock edge too soon after select");
  high_time_a: assert property ($rose(sclk_i) |-> high_half)
    else $error("link clock high time too short");
  low_time_a: assert property ($fell(sclk_i) && !cs_n_i |-> low_half)
    else $error("link clock low time too short");
  // host data must not move near any edge, both edges count in double rate
  mosi_setup_a: assert property ($changed(sclk_i) |-> $stable(mosi_i) [*3])
    else $error("host data moves at a clock edge");
  miso_hold_a: assert property (cs_n_i [*2] |-> $stable(miso_i))
    else $error("device data moves while deselected");
  // config may only load once a frame is over
  cfg_load_a: assert property ($changed(internal_cfg_i) |-> cs_n_i && $past(cs_n_i))
    else $error("internal config changed inside a frame");
  rsvd_zero_a: assert property (internal_cfg_i[2] == 1'b0)
    else $error("reserved config bit set");
  xip_map_a: assert property ($stable(internal_cfg_i) [*2] |->
    execute_in_place_i == !internal_cfg_i[3])
    else $error("execute in place does not follow config");
endmodule

// [verif/test_flash_volatile_read_config.sv]
// Purpose: bench for both ends of the volatile read config link
// Assumes: register reads answer one cycle after the strobe
// Notes:   array byte mirrors the low address byte, so wrap order shows
`timescale 1ns/1ns
module test_flash_volatile_read_config;
  import fvc_pkg::*;
  logic        core_clk_i;
  logic        rst_n_i;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic        double_rate_i;
  logic [23:0] mem_addr_o;
  logic [7:0]  mem_data_i;
  logic [7:0]  internal_cfg_o;
  logic        execute_in_place_o;
  int          error_cnt;
  int          comparisons;
  logic [31:0] d;
  logic [7:0]  m;
  logic [3:0]  dc [4] = '{4'h0, 4'h1, 4'hE, 4'h3};
  fvc_link_if link ();
  fvc_host fvc_host_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(link.host),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
  fvc_dev fvc_dev_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(link.dev),
    .double_rate_i(double_rate_i), .mem_data_i(mem_data_i), .mem_addr_o(mem_addr_o),
    .internal_cfg_o(internal_cfg_o), .execute_in_place_o(execute_in_place_o));
  fvc_link_chk fvc_link_chk_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .sclk_i(link.sclk), .cs_n_i(link.cs_n), .mosi_i(link.mosi), .miso_i(link.miso),
    .internal_cfg_i(internal_cfg_o), .execute_in_place_i(execute_in_place_o));
  // array model answers at once, well inside the one cycle allowed
  assign mem_data_i = mem_addr_o[7:0];
  // 100 MHz core clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    v = reg_rdata_o;
  endtask
  // bounded poll, a hang counts as a mismatch
  task automatic wait_flag(input int b, input logic lvl);
    logic [31:0] s;
    for (int n = 0; n < 1000; n++) begin
      rd(REG_STATUS, s);
      if (s[b] === lvl) return;
    end
    error_cnt++;
  endtask
  task automatic xfer(input fvc_op_t op, input logic ddr, input logic [23:0] a,
                      input logic [7:0] len, input logic [7:0] wb);
    wr(REG_ADDR, {8'h00, a});
    // changed on a clock edge, device latches it at frame start
    double_rate_i <= ddr;
    wr(REG_DATA, {16'h0000, len, wb});
    wr(REG_CTRL, {28'h0000000, 1'b1, ddr, op});
  endtask
  // slow taking of bytes also stalls the link between them
  task automatic take(input logic [7:0] exp);
    wait_flag(STAT_RXV_BIT, 1'b1);
    rd(REG_RDATA, d);
    check(d[7:0], exp);
  endtask
  // frame end plus time for the config copy to land
  task automatic settle();
    wait_flag(STAT_BUSY_BIT, 1'b0);
    repeat (6) @(posedge core_clk_i);
  endtask
  task automatic test_done();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // tests need under 10k cycles; give up after 20k
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
  initial begin
    rst_n_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h00000000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    double_rate_i = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    check(internal_cfg_o, CFG_RESET);
    check({7'h00, execute_in_place_o}, 8'h00);
    rd(8'h20, d);
    check(d[7:0], 8'h00);
    xfer(OP_RD_CFG, 1'b0, 24'h000000, 8'h00, 8'h00);
    // a start while busy must be refused entirely
    wr(REG_CTRL, {28'h0000000, 1'b1, 1'b1, OP_TUNE_RD});
    take(CFG_RESET);
    settle();
    rd(REG_CTRL, d);
    check(d[7:0], 8'h00);
    // reserved bit written high must be dropped
    xfer(OP_WR_CFG, 1'b0, 24'h000000, 8'h00, 8'h7E);
    settle();
    check(internal_cfg_o, 8'h7A);
    rd(REG_STATUS, d);
    check(d[15:8], 8'h7A);
    check({7'h00, execute_in_place_o}, 8'h00);
    xfer(OP_RD_CFG, 1'b0, 24'h000000, 8'h01, 8'h00);
    take(8'h7A);
    take(8'h7A);
    settle();
    xfer(OP_WR_CFG, 1'b0, 24'h000000, 8'h00, 8'h36);
    settle();
    check(internal_cfg_o, 8'h32);
    check({7'h00, execute_in_place_o}, 8'h01);
    // every wrap code, dummy alias and extremes, both rates
    for (int w = 0; w < 4; w++) begin
      xfer(OP_WR_CFG, 1'b0, 24'h000000, 8'h00, {dc[w], 2'b10, 2'(w)});
      settle();
      m = (w == 0) ? 8'h0F : (w == 1) ? 8'h1F : (w == 2) ? 8'h3F : 8'hFF;
      xfer(OP_FAST_RD, 1'(w), 24'h00003E, 8'h03, 8'h00);
      for (int i = 0; i < 4; i++) begin
        take((8'h3E & ~m) | ((8'h3E + 8'(i)) & m));
      end
      settle();
    end
    rd(REG_ADDR, d);
    check(d[7:0], 8'h3E);
    for (int r = 0; r < 2; r++) begin
      xfer(OP_TUNE_RD, 1'(r), 24'h000000, 8'h01, 8'h00);
      take(TUNE_PATTERN);
      take(TUNE_PATTERN);
      settle();
    end
    test_done();
  end
endmodule
